// file: design/sfc_pkg.sv
// Purpose: shared constants for the serial frame control of a 14-bit SAR converter
// Assumes: link clock idles high between frames; device clocked by the link clock
// Notes: the host end derives the link clock from its own clock by a divider
//
// Overview of operation
// - power-up sampling; CS fall starts conversion
// - SDO driven only while CS low
// - result is straight unsigned binary
// - host gives at least eighteen falling edges
// - conversion done, device returns to sampling
// - host keeps 95 ns sampling window
// - first frame after power-up outputs zeros
// - frame shifts out previous frame's result
// - leading zero on CS falling edge
// - MSB on rising after first falling
// - zeros after all fourteen bits
// - short frame gives invalid next result
// - calibration corrects all later conversions
// - host calibrates after power-up, condition changes
// - first frame of 24 clocks calibrates
// - power-up calibration frame outputs zeros
// - early CS rise aborts power-up calibration
// - calibration frame length and SCLK limit
// - frame of 64 clocks calibrates later
// - running calibration: result then zeros
// - early CS rise aborts running calibration
package sfc_pkg;
    localparam int          DATA_W         = 14;
    localparam int          CNT_W          = 7;
    localparam logic [6:0]  CONV_EDGES     = 7'h12;
    localparam logic [6:0]  CAL_ENTRY_EDGE = 7'h13;
    localparam logic [6:0]  CAL_PU_EDGES   = 7'h18;
    localparam logic [6:0]  CAL_RUN_EDGES  = 7'h40;
    localparam logic [6:0]  FIRST_BIT_EDGE = 7'h02;
    localparam logic [6:0]  LAST_BIT_EDGE  = 7'h0F;
    localparam logic [13:0] RESULT_RESET   = 14'h0000;
    localparam logic [13:0] INVALID_WORD   = 14'h3FFF;
    localparam logic [13:0] FULL_SCALE     = 14'h3FFF;
    localparam int          CLOCK_NS       = 50;
    localparam int          MIN_SAMPLE_NS  = 95;
    localparam int          MIN_SAMPLE_CYC = (MIN_SAMPLE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int          SCLK_MAX_MHZ   = 60;
    localparam int          CLOCK_MHZ      = 1000 / CLOCK_NS;
    localparam int          HALF_DEFAULT   = 3;

    typedef enum logic [2:0] {
        SAMPLING_STATE   = 3'b001,
        CONVERT_STATE    = 3'b010,
        OFFSET_CAL_STATE = 3'b100
    } sfc_mode_t;

    typedef enum logic [5:0] {
        H_IDLE  = 6'b000001,
        H_SETUP = 6'b000010,
        H_LOW   = 6'b000100,
        H_HIGH  = 6'b001000,
        H_CLOSE = 6'b010000,
        H_GAP   = 6'b100000
    } sfc_host_t;
endpackage : sfc_pkg

// file: design/sfc_link_if.sv
// Purpose: the serial link between host and converter
// Assumes: the host end resolves the SDO wire from sdoOe
// Notes: no clocking block; sclk is the link clock
`timescale 1ns/1ps
interface sfc_link_if;
    logic csN;   // frame select, active low
    logic sclk;  // link clock from host
    logic sdo;   // serial data from device
    logic sdoOe; // device drives sdo when high

    modport dev  (input csN, input sclk, output sdo, output sdoOe);
    modport host (output csN, output sclk, input sdo, input sdoOe);
endinterface : sfc_link_if

// file: design/sfc_device.sv
// Purpose: converter end: frame state, result shift-out, offset calibration
// Assumes: sampleIn stands for the held analog input and is steady around each frame
// Notes: link logic runs on sclk; CS high clears all frame state asynchronously
`timescale 1ns/1ps
module sfc_device #(
    parameter logic [13:0] OFFSET_ERR = 14'h0002
) (
    input  wire logic        clock,    // user-side clock
    input  wire logic        rst_b,    // power-up reset, active low
    sfc_link_if.dev          link,     // serial link
    input  wire logic [13:0] sampleIn, // sampled input code
    output logic             calDone,  // offset calibration in effect
    output logic             convBusy  // conversion state, synced
);
    sfc_pkg::sfc_mode_t mode;
    logic [6:0]  edgeCnt;
    logic [6:0]  next_edgeCnt;
    logic [13:0] shiftReg;
    logic [13:0] sampleHold;
    logic [13:0] result;
    logic [13:0] startWord;
    logic [14:0] rawSum;
    logic [13:0] converted;
    logic        sdoReg;
    logic        isFirst;
    logic        powerFirst;
    logic        convOk;
    logic        calibrated;
    logic        frameClr;
    logic        calSync1;
    logic        calSync2;
    logic        busySync1;
    logic        busySync2;

    // clear frame state while CS is high, so the leading bit is zero on CS fall
    assign frameClr = link.csN | ~rst_b;

    // pin enable follows CS directly: the link clock is stopped around the frame edges
    assign link.sdoOe = ~link.csN;
    assign link.sdo   = sdoReg;

    assign next_edgeCnt = (edgeCnt == 7'h7F) ? edgeCnt : edgeCnt + 7'h01;

    // word launched this frame: the previous frame's result
    always_comb begin
        if (powerFirst) begin
            startWord = sfc_pkg::RESULT_RESET;
        end else if (!convOk) begin
            startWord = sfc_pkg::INVALID_WORD;
        end else begin
            startWord = result;
        end
    end

    // uncalibrated converter carries an offset error, clipped at full scale
    assign rawSum = {1'b0, sampleHold} + {1'b0, OFFSET_ERR};

    always_comb begin
        if (calibrated) begin
            converted = sampleHold;
        end else if (rawSum[14]) begin
            converted = sfc_pkg::FULL_SCALE;
        end else begin
            converted = rawSum[13:0];
        end
    end

    // rising-edge count within the frame; edge n follows falling edge n
    always_ff @(posedge link.sclk or posedge frameClr) begin
        if (frameClr) begin
            edgeCnt <= '0;
        end else begin
            edgeCnt <= next_edgeCnt;
        end
    end

    // conversion state; CS high forces sampling and aborts calibration
    always_ff @(posedge link.sclk or posedge frameClr) begin
        if (frameClr) begin
            mode <= sfc_pkg::SAMPLING_STATE;
        end else begin
            if (edgeCnt == 7'h00) begin
                mode <= sfc_pkg::CONVERT_STATE;
            end else if (next_edgeCnt == sfc_pkg::CONV_EDGES) begin
                mode <= sfc_pkg::SAMPLING_STATE;
            end else if (next_edgeCnt == sfc_pkg::CAL_ENTRY_EDGE) begin
                mode <= sfc_pkg::OFFSET_CAL_STATE;
            end else if (mode == sfc_pkg::OFFSET_CAL_STATE &&
                         ((isFirst && next_edgeCnt == sfc_pkg::CAL_PU_EDGES) ||
                          next_edgeCnt == sfc_pkg::CAL_RUN_EDGES)) begin
                mode <= sfc_pkg::SAMPLING_STATE;
            end
        end
    end

    // output shifter: MSB on the first rising edge, zeros once empty
    always_ff @(posedge link.sclk or posedge frameClr) begin
        if (frameClr) begin
            sdoReg   <= 1'b0;
            shiftReg <= '0;
            isFirst  <= 1'b0;
        end else if (edgeCnt == 7'h00) begin
            sdoReg   <= startWord[13];
            shiftReg <= {startWord[12:0], 1'b0};
            isFirst  <= powerFirst;
        end else begin
            sdoReg   <= shiftReg[13] & ~isFirst;
            shiftReg <= {shiftReg[12:0], 1'b0};
        end
    end

    // the input is held from the start of conversion
    always_ff @(posedge link.sclk or posedge frameClr) begin
        if (frameClr) begin
            sampleHold <= '0;
        end else if (edgeCnt == 7'h00) begin
            sampleHold <= sampleIn;
        end
    end

    // power-up markers: cleared by the first frame, whatever its length
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            powerFirst <= 1'b1;
        end else if (!link.csN && edgeCnt == 7'h00) begin
            powerFirst <= 1'b0;
        end
    end

    // a frame that stops short of eighteen edges leaves the result invalid
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            convOk <= 1'b1;
            result <= sfc_pkg::RESULT_RESET;
        end else if (!link.csN && edgeCnt == 7'h00) begin
            convOk <= 1'b0;
        end else if (!link.csN && next_edgeCnt == sfc_pkg::CONV_EDGES &&
                     edgeCnt != next_edgeCnt) begin
            convOk <= 1'b1;
            result <= converted;
        end
    end

    // calibration holds until power is removed
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            calibrated <= 1'b0;
        end else if (!link.csN && mode == sfc_pkg::OFFSET_CAL_STATE &&
                     ((isFirst && next_edgeCnt == sfc_pkg::CAL_PU_EDGES) ||
                      next_edgeCnt == sfc_pkg::CAL_RUN_EDGES)) begin
            calibrated <= 1'b1;
        end
    end

    // status levels into the user clock domain
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            calSync1  <= 1'b0;
            calSync2  <= 1'b0;
            busySync1 <= 1'b0;
            busySync2 <= 1'b0;
        end else begin
            calSync1  <= calibrated;
            calSync2  <= calSync1;
            busySync1 <= (mode == sfc_pkg::CONVERT_STATE);
            busySync2 <= busySync1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            calDone  <= 1'b0;
            convBusy <= 1'b0;
        end else begin
            calDone  <= calSync2;
            convBusy <= busySync2;
        end
    end
endmodule : sfc_device

// file: design/sfc_host.sv
// Purpose: host end: frames of a chosen clock count, collects the result word
// Assumes: HALF_CYCLES of at least three so the synced SDO has settled
// Notes: the link clock is divided from clock and idles high
`timescale 1ns/1ps
module sfc_host #(
    parameter int HALF_CYCLES = sfc_pkg::HALF_DEFAULT
) (
    input  wire logic        clock,     // host clock
    input  wire logic        rst_b,     // reset, active low
    sfc_link_if.host         link,      // serial link
    input  wire logic        startReq,  // start one frame
    input  wire logic [6:0]  frameLen,  // SCLK cycles in the frame
    output logic             ready,     // may take startReq
    output logic [13:0]      dataOut,   // word of the frame
    output logic             dataValid  // dataOut new, one cycle
);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
    localparam logic [7:0] GAP_LAST  = 8'(sfc_pkg::MIN_SAMPLE_CYC - 1);

    sfc_pkg::sfc_host_t state;
    logic [7:0]  halfCnt;
    logic [6:0]  lenHold;
    logic [6:0]  fallCnt;
    logic [13:0] shiftIn;
    logic        sdoSync1;
    logic        sdoSync2;
    logic        stepDone;
    logic        frameEnd;
    logic        fallNow;

    // the gap after a frame is timed separately from the clock halves
    always_comb begin
        if (state == sfc_pkg::H_GAP) begin
            stepDone = (halfCnt == GAP_LAST);
        end else begin
            stepDone = (halfCnt == HALF_LAST);
        end
    end

    assign frameEnd = (fallCnt >= lenHold);
    assign fallNow  = stepDone && ((state == sfc_pkg::H_SETUP) ||
                                   (state == sfc_pkg::H_HIGH && !frameEnd));

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= sfc_pkg::H_IDLE;
        end else begin
            case (state)
                sfc_pkg::H_IDLE: begin
                    if (startReq) begin
                        state <= sfc_pkg::H_SETUP;
                    end
                end
                sfc_pkg::H_SETUP: begin
                    if (stepDone) begin
                        state <= sfc_pkg::H_LOW;
                    end
                end
                sfc_pkg::H_LOW: begin
                    if (stepDone) begin
                        state <= sfc_pkg::H_HIGH;
                    end
                end
                sfc_pkg::H_HIGH: begin
                    if (stepDone && frameEnd) begin
                        state <= sfc_pkg::H_CLOSE;
                    end else if (stepDone) begin
                        state <= sfc_pkg::H_LOW;
                    end
                end
                sfc_pkg::H_CLOSE: begin
                    state <= sfc_pkg::H_GAP;
                end
                sfc_pkg::H_GAP: begin
                    if (stepDone) begin
                        state <= sfc_pkg::H_IDLE;
                    end
                end
                default: begin
                    state <= sfc_pkg::H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            halfCnt <= '0;
        end else if (state == sfc_pkg::H_IDLE || state == sfc_pkg::H_CLOSE || stepDone) begin
            halfCnt <= '0;
        end else begin
            halfCnt <= halfCnt + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lenHold <= '0;
        end else if (state == sfc_pkg::H_IDLE && startReq) begin
            lenHold <= frameLen;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fallCnt <= '0;
        end else if (state == sfc_pkg::H_IDLE) begin
            fallCnt <= '0;
        end else if (fallNow) begin
            fallCnt <= fallCnt + 7'h01;
        end
    end

    // link clock idles high, so the frame opens and closes with it high
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            link.sclk <= 1'b1;
        end else if (fallNow) begin
            link.sclk <= 1'b0;
        end else if (state == sfc_pkg::H_LOW && stepDone) begin
            link.sclk <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            link.csN <= 1'b1;
        end else if (state == sfc_pkg::H_IDLE && startReq) begin
            link.csN <= 1'b0;
        end else if (state == sfc_pkg::H_HIGH && stepDone && frameEnd) begin
            link.csN <= 1'b1;
        end
    end

    // a released pin reads as zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sdoSync1 <= 1'b0;
            sdoSync2 <= 1'b0;
        end else begin
            sdoSync1 <= link.sdo & link.sdoOe;
            sdoSync2 <= sdoSync1;
        end
    end

    // bits are taken on falling edges two to fifteen; the first carries the leading zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            shiftIn <= '0;
        end else if (fallNow && fallCnt >= 7'h01 && fallCnt <= 7'h0E) begin
            shiftIn <= {shiftIn[12:0], sdoSync2};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dataOut   <= '0;
            dataValid <= 1'b0;
        end else begin
            dataValid <= (state == sfc_pkg::H_CLOSE);
            if (state == sfc_pkg::H_CLOSE) begin
                dataOut <= shiftIn;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ready <= 1'b1;
        end else if (state == sfc_pkg::H_IDLE && startReq) begin
            ready <= 1'b0;
        end else if (state == sfc_pkg::H_GAP && stepDone) begin
            ready <= 1'b1;
        end
    end
endmodule : sfc_host

// file: verif/sfc_link_props.sv
// Purpose: link checks between host and converter ends
// Assumes: sclk is divided from clock, so the host clock samples it cleanly
// Notes: counts are of sclk falling edges within an open frame
`timescale 1ns/1ps
module sfc_link_props (
    input wire logic clock, // host clock
    input wire logic rst_b, // reset, active low
    input wire logic csN,   // frame select
    input wire logic sclk,  // link clock
    input wire logic sdo,   // device data
    input wire logic sdoOe  // device drive enable
);
    logic [6:0] falls;
    logic       firstFrame;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clock) begin
        if (!rst_b || csN) falls <= 7'h00;
        else if ($fell(sclk)) falls <= falls + 7'h01;
    end
    // the first frame after reset carries no earlier result
    always_ff @(posedge clock) begin
        if (!rst_b) firstFrame <= 1'b1;
        else if ($rose(csN)) firstFrame <= 1'b0;
    end
    property p_hiz; csN |-> !sdoOe; endproperty
    a_hiz: assert property (p_hiz) else $error("sdo driven while frame closed");
    property p_drive; (!csN) [*3] |-> sdoOe; endproperty
    a_drive: assert property (p_drive) else $error("sdo not driven in open frame");
    property p_open; $fell(csN) |-> sclk; endproperty
    a_open: assert property (p_open) else $error("frame opened with sclk low");
    property p_lead; $fell(sclk) && !csN && falls == 7'h00 |-> !sdo; endproperty
    a_lead: assert property (p_lead) else $error("leading bit not zero");
    property p_tail; $fell(sclk) && !csN && falls >= 7'h0F |-> !sdo; endproperty
    a_tail: assert property (p_tail) else $error("bit after the result not zero");
    property p_first; firstFrame && sdoOe |-> !sdo; endproperty
    a_first: assert property (p_first) else $error("first frame not all zeros");
    property p_hold; $fell(sclk) && !csN |=> csN || $stable(sdo); endproperty
    a_hold: assert property (p_hold) else $error("sdo moved after falling sclk");
    property p_window; $rose(csN) |-> csN [*2]; endproperty
    a_window: assert property (p_window) else $error("sampling window too short");
    property p_slow; $fell(sclk) |=> !sclk; endproperty
    a_slow: assert property (p_slow) else $error("sclk low phase too short");
endmodule : sfc_link_props

// file: verif/sar_adc_serial_frame_control_tb.sv
// Purpose: drives frames through host and device ends and checks the words
// Assumes: corrected results equal sampleIn once calibration is in effect
// Notes: link clock comes from the host divider, not from the bench
`timescale 1ns/1ps
module sar_adc_serial_frame_control_tb;
    logic        clock    = 1'b0;
    logic        rst_b    = 1'b0;
    logic        startReq = 1'b0;
    logic [6:0]  frameLen = 7'h12;
    logic [13:0] sampleIn = 14'h0000;
    logic        ready;
    logic        dataValid;
    logic        calDone;
    logic        convBusy;
    logic [13:0] dataOut;
    logic [13:0] got;
    int          num_errors  = 0;
    int          check_count = 0;
    sfc_link_if link ();
    always #25 clock = ~clock;
    sfc_device sfc_device_i (.clock(clock), .rst_b(rst_b), .link(link), .sampleIn(sampleIn),
        .calDone(calDone), .convBusy(convBusy));
    sfc_host sfc_host_i (.clock(clock), .rst_b(rst_b), .link(link), .startReq(startReq),
        .frameLen(frameLen), .ready(ready), .dataOut(dataOut), .dataValid(dataValid));
    sfc_link_props sfc_link_props_i (.clock(clock), .rst_b(rst_b), .csN(link.csN), .sclk(link.sclk),
        .sdo(link.sdo), .sdoOe(link.sdoOe));
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : do_reset
    // waits are bounded so a stuck host shows as a mismatch, not a hang
    task automatic frame(input logic [6:0] len, input logic [13:0] smp);
        repeat (4000) begin
            @(posedge clock);
            if (ready === 1'b1) break;
        end
        sampleIn <= smp;
        frameLen <= len;
        startReq <= 1'b1;
        @(posedge clock);
        startReq <= 1'b0;
        got = 14'hXXXX;
        repeat (4000) begin
            @(posedge clock);
            if (dataValid === 1'b1) got = dataOut;
            if (ready === 1'b1) break;
        end
        check({13'h0000, ready}, 14'h0001);
        repeat (6) @(posedge clock);
    endtask : frame
    task automatic t_powerup_cal();
        frame(sfc_pkg::CAL_PU_EDGES, 14'h0000);
        check(got, 14'h0000);
        check({13'h0000, calDone}, 14'h0001);
    endtask : t_powerup_cal
    task automatic t_results();
        frame(sfc_pkg::CONV_EDGES, 14'h1234);
        frame(sfc_pkg::CONV_EDGES, sfc_pkg::FULL_SCALE);
        check(got, 14'h1234);
        frame(sfc_pkg::CONV_EDGES, 14'h0000);
        check(got, sfc_pkg::FULL_SCALE);
        frame(sfc_pkg::CONV_EDGES, 14'h0000);
        check(got, 14'h0000);
        check({13'h0000, convBusy}, 14'h0000);
    endtask : t_results
    task automatic t_short();
        frame(7'h11, 14'h0ABC);
        frame(sfc_pkg::CONV_EDGES, 14'h0155);
        check(got, sfc_pkg::INVALID_WORD);
        frame(sfc_pkg::CONV_EDGES, 14'h0000);
        check(got, 14'h0155);
    endtask : t_short
    task automatic t_run_cal();
        frame(sfc_pkg::CAL_RUN_EDGES, 14'h2000);
        check(got, 14'h0000);
        check({13'h0000, calDone}, 14'h0001);
        frame(7'h28, 14'h0777);
        check({13'h0000, convBusy}, 14'h0000);
        frame(sfc_pkg::CONV_EDGES, 14'h0000);
        check(got, 14'h0777);
    endtask : t_run_cal
    task automatic t_abort_cal();
        do_reset();
        frame(7'h17, 14'h0000);
        check({13'h0000, calDone}, 14'h0000);
        do_reset();
        frame(sfc_pkg::CONV_EDGES, 14'h0AAA);
        check(got, 14'h0000);
    endtask : t_abort_cal
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        do_reset();
        t_powerup_cal();
        t_results();
        t_short();
        t_run_cal();
        t_abort_cal();
        tally_and_finish();
    end
    // thirteen frames of at most 64 slow clocks fit well inside this
    initial begin
        #3000000;
        num_errors++;
        tally_and_finish();
    end
endmodule : sar_adc_serial_frame_control_tb
